/* File: logic/sast_top.sv */
// converter sequencing timing and synchronous serial port, device side
`timescale 1ns/1ns
`include "sast_defines.svh"
module sast_top #(
  parameter int unsigned PU_CYCLES = `SAST_PU_CYCLES
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   srst_i,
  input  wire logic                   conversion_clock_i,
  input  wire logic                   sclk_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   serial_in_i,
  input  wire logic                   convert_strobe_i,
  input  wire logic                   powerdown_pin_i,
  input  wire logic                   res8_i,
  input  wire sast_pkg::sast_acq_sel_t acq_sel_i,
  input  wire logic [15:0]            result_i,
  output logic                        sdo_o,
  output logic                        sdo_oe_o,
  output logic                        output_ready_flag_o,
  output logic                        eoc_o,
  output logic                        sample_o,
  output logic                        result_bad_o
);
  import sast_pkg::*;

  logic ck_q, ck_rise, sk_q, sk_rise, sk_fall, cs_q, cs_rise, cs_fall;
  logic di_q, cv_q, pd_q, pd_rise, pd_fall;

  sast_sync u_ck (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .d_i(conversion_clock_i),
                  .q_o(ck_q), .rise_o(ck_rise), .fall_o());
  sast_sync u_sk (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .d_i(sclk_i),
                  .q_o(sk_q), .rise_o(sk_rise), .fall_o(sk_fall));
  // select and strobe idle high
  sast_sync #(.RST_VAL(1'b1)) u_cs (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .d_i(cs_n_i),
                  .q_o(cs_q), .rise_o(cs_rise), .fall_o(cs_fall));
  sast_sync u_di (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .d_i(serial_in_i),
                  .q_o(di_q), .rise_o(), .fall_o());
  sast_sync #(.RST_VAL(1'b1)) u_cv (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .d_i(convert_strobe_i),
                  .q_o(cv_q), .rise_o(), .fall_o());
  sast_sync u_pd (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .d_i(powerdown_pin_i),
                  .q_o(pd_q), .rise_o(pd_rise), .fall_o(pd_fall));

  typedef struct packed {
    sast_seq_t                  seq;
    logic [12:0]                ck_cnt;
    logic [`SAST_PU_CNT_W-1:0]  pu_cnt;
    logic                       cal_req;
    logic                       az_req;
    logic                       pu_req;
    logic                       sw_pd;
    logic [4:0]                 bit_cnt;
    logic [7:0]                 cmd;
    logic [15:0]                shreg;
    logic [3:0]                 cv_cnt;
    logic                       cv_seen;
    logic                       sdo;
    logic                       sdo_oe;
    logic                       output_ready_flag;
    logic                       eoc;
    logic                       sample;
    logic                       bad;
  } sast_st_t;

  sast_st_t st, next_st;
  logic [5:0] acq_len;

  always_comb begin
    unique case (acq_sel_i)
      2'h0: acq_len = `SAST_ACQ_6;
      2'h1: acq_len = `SAST_ACQ_10;
      2'h2: acq_len = `SAST_ACQ_18;
      2'h3: acq_len = `SAST_ACQ_34;
    endcase
  end

  always_comb begin
    next_st = st;
    // serial side: select edges and shifting
    if (cs_fall) begin
      next_st.sdo_oe  = 1'b1;
      next_st.sdo     = st.shreg[15];
      next_st.output_ready_flag     = 1'b0;
      next_st.bit_cnt = '0;
      next_st.cv_cnt  = '0;
      next_st.cv_seen = 1'b0;
    end else if (cs_rise) begin
      next_st.sdo_oe = 1'b0;
    end else if (!cs_q) begin
      if (sk_rise) begin
        next_st.cmd = {st.cmd[6:0], di_q};
        if (st.cv_cnt < `SAST_CONVERT_STROBE_WIN_SK) begin
          next_st.cv_cnt = st.cv_cnt + 4'h1;
          // active-low strobe sampled once, on the last rise of its window
          if (st.cv_cnt == `SAST_CONVERT_STROBE_WIN_SK - 4'h1 && !cv_q) begin
            next_st.cv_seen = 1'b1;
          end
        end
      end
      if (sk_fall && st.bit_cnt < `SAST_DATA_BITS) begin
        next_st.shreg   = {st.shreg[14:0], 1'b0};
        next_st.sdo     = st.shreg[14];
        next_st.bit_cnt = st.bit_cnt + 5'd1;
        if (st.bit_cnt == `SAST_CMD_BITS - 5'd1) begin
          // command complete on this falling edge
          if (st.cmd == `SAST_CMD_CAL) next_st.cal_req = 1'b1;
          if (st.cmd == `SAST_CMD_AZ) next_st.az_req = 1'b1;
          if (st.cmd == `SAST_CMD_PWRUP) begin
            next_st.sw_pd  = 1'b0;
            next_st.pu_req = 1'b1;
          end
          if (st.cmd == `SAST_CMD_PWRDN) next_st.sw_pd = 1'b1;
          // ready flag back high once command shifting is done
          next_st.output_ready_flag = 1'b1;
        end
      end
    end
    // conversion sequencer, paced by conversion clock rising edges; the wake count runs on clk_sys_i cycles
    if (pd_rise) begin
      if (st.seq == SAST_CONVERT_STROBE || st.seq == SAST_ACQ) begin
        next_st.bad = 1'b1;
      end
      next_st.seq    = SAST_PDOWN;
      next_st.eoc    = 1'b0;
      next_st.sample = 1'b0;
    end else if (pd_fall) begin
      next_st.seq    = SAST_WAKE;
      next_st.pu_cnt = '0;
    end else begin
      unique case (st.seq)
        SAST_PDOWN: begin
          if (st.pu_req && !pd_q) begin
            next_st.seq    = SAST_WAKE;
            next_st.pu_cnt = '0;
          end
        end
        SAST_WAKE: begin
          next_st.pu_req = 1'b0;
          next_st.pu_cnt = st.pu_cnt + `SAST_PU_CNT_W'(1);
          // fixed wake time well inside the power-up limit
          if (st.pu_cnt == `SAST_PU_CNT_W'(PU_CYCLES / 2)) begin
            next_st.eoc = 1'b1;
            next_st.seq = SAST_IDLE;
          end
        end
        SAST_IDLE: begin
          if (st.sw_pd) begin
            next_st.seq = SAST_PDOWN;
            next_st.eoc = 1'b0;
          end else if (st.cal_req || st.az_req) begin
            next_st.seq    = SAST_SYNC;
            next_st.ck_cnt = '0;
          end else if (st.cv_seen) begin
            // strobe seen low in its window: start sampling
            next_st.cv_seen = 1'b0;
            next_st.seq     = SAST_ACQ;
            next_st.ck_cnt  = '0;
            next_st.sample  = 1'b1;
            next_st.eoc     = 1'b0;
            next_st.bad     = 1'b0;
          end
        end
        SAST_SYNC: begin
          if (ck_rise) begin
            next_st.ck_cnt = st.ck_cnt + 13'd1;
            if (st.ck_cnt == `SAST_SYNC_CYCLES) begin
              next_st.ck_cnt = '0;
              next_st.seq    = st.cal_req ? SAST_CAL : SAST_AZ;
              next_st.eoc    = 1'b0;
            end
          end
        end
        SAST_CAL, SAST_AZ: begin
          if (ck_rise) begin
            next_st.ck_cnt = st.ck_cnt + 13'd1;
            if (st.ck_cnt == (st.seq == SAST_CAL ? `SAST_CAL_CYCLES : `SAST_AZ_CYCLES) - 13'd1) begin
              next_st.seq     = SAST_IDLE;
              next_st.cal_req = 1'b0;
              next_st.az_req  = 1'b0;
              next_st.eoc     = 1'b1;
            end
          end
        end
        SAST_ACQ: begin
          if (ck_rise) begin
            next_st.ck_cnt = st.ck_cnt + 13'd1;
            if (st.ck_cnt == {7'h00, acq_len} - 13'd1) begin
              next_st.sample = 1'b0;
              next_st.ck_cnt = '0;
              next_st.seq    = SAST_CONVERT_STROBE;
            end
          end
        end
        SAST_CONVERT_STROBE: begin
          if (ck_rise) begin
            next_st.ck_cnt = st.ck_cnt + 13'd1;
            if (st.ck_cnt == (res8_i ? `SAST_CONV8_CYCLES : `SAST_CONV12_CYCLES) - 13'd1) begin
              next_st.seq = SAST_IDLE;
              next_st.eoc = 1'b1;
              if (cs_q) next_st.shreg = result_i; // load only between transfers
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st     <= '0;
      st.seq <= SAST_IDLE;
      st.output_ready_flag <= 1'b1;
      st.eoc <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign sdo_o               = st.sdo;
  assign sdo_oe_o            = st.sdo_oe;
  assign output_ready_flag_o = st.output_ready_flag;
  assign eoc_o               = st.eoc;
  assign sample_o            = st.sample;
  assign result_bad_o        = st.bad;

  // conversion clock edges seen during a sampling window
  logic [5:0] acq_edges;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !st.sample) begin
      acq_edges <= '0;
    end else if (ck_rise) begin
      acq_edges <= acq_edges + 6'd1;
    end
  end

  property p_acq_len;
    @(posedge clk_sys_i) disable iff (srst_i)
      $fell(st.sample) && !pd_q |-> $past(acq_edges) == acq_len - 6'd1;
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("sampling window length wrong");

  property p_cal_len;
    @(posedge clk_sys_i) disable iff (srst_i)
      st.seq == SAST_CAL |-> st.ck_cnt < `SAST_CAL_CYCLES;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration overran");

  property p_az_len;
    @(posedge clk_sys_i) disable iff (srst_i)
      st.seq == SAST_AZ |-> st.ck_cnt < `SAST_AZ_CYCLES;
  endproperty
  a_az_len: assert property (p_az_len) else $error("auto-zero overran");

  property p_sync;
    @(posedge clk_sys_i) disable iff (srst_i || pd_q)
      st.seq == SAST_SYNC && next_st.seq != SAST_SYNC |-> ck_rise && st.ck_cnt == `SAST_SYNC_CYCLES;
  endproperty
  a_sync: assert property (p_sync) else $error("calibration start not synchronised");

  sequence s_cs_fall;
    cs_fall;
  endsequence
  property p_cs_dor;
    @(posedge clk_sys_i) disable iff (srst_i)
      s_cs_fall |=> !output_ready_flag_o && sdo_oe_o;
  endproperty
  a_cs_dor: assert property (p_cs_dor) else $error("select fall not answered");

  property p_cs_rel;
    @(posedge clk_sys_i) disable iff (srst_i)
      cs_rise |=> !sdo_oe_o;
  endproperty
  a_cs_rel: assert property (p_cs_rel) else $error("output not released");

  property p_sdo_edge;
    @(posedge clk_sys_i) disable iff (srst_i)
      !cs_q && !cs_fall && !sk_fall |=> $stable(sdo_o);
  endproperty
  a_sdo_edge: assert property (p_sdo_edge) else $error("output changed off a falling edge");

  property p_pd_bad;
    @(posedge clk_sys_i) disable iff (srst_i)
      pd_rise && st.seq == SAST_CONVERT_STROBE |=> result_bad_o && !eoc_o;
  endproperty
  a_pd_bad: assert property (p_pd_bad) else $error("power-down not flagged");

  property p_wake;
    @(posedge clk_sys_i) disable iff (srst_i || pd_q)
      st.seq == SAST_WAKE |-> st.pu_cnt <= `SAST_PU_CNT_W'(PU_CYCLES / 2);
  endproperty
  a_wake: assert property (p_wake) else $error("wake too slow");
endmodule // sast_top

/* File: logic/sast_defines.svh */
// timing and field constants for the converter sequencing and serial port block
`ifndef SAST_DEFINES_SVH
`define SAST_DEFINES_SVH
`define SAST_CLK_NS          10
`define SAST_CAL_CYCLES      13'd4944
`define SAST_AZ_CYCLES       13'd76
`define SAST_SYNC_CYCLES     13'd2
`define SAST_CONV12_CYCLES   13'd44
`define SAST_CONV8_CYCLES    13'd21
`define SAST_PU_TIME_US      250
`define SAST_PU_CYCLES       (`SAST_PU_TIME_US * 1000 / `SAST_CLK_NS)
`define SAST_PU_CNT_W        15
`define SAST_CMD_BITS        5'd8
`define SAST_DATA_BITS       5'd16
`define SAST_CONVERT_STROBE_WIN_SK     4'd8
`define SAST_ACQ_6           6'd6
`define SAST_ACQ_10          6'd10
`define SAST_ACQ_18          6'd18
`define SAST_ACQ_34          6'd34
`define SAST_CMD_CAL         8'h08
`define SAST_CMD_AZ          8'h09
`define SAST_CMD_PWRUP       8'h0A
`define SAST_CMD_PWRDN       8'h0B
`endif

/* File: logic/sast_pkg.sv */
// types for the converter sequencing and serial port block
package sast_pkg;
  typedef enum logic [2:0] {
    SAST_IDLE, SAST_SYNC, SAST_CAL, SAST_AZ, SAST_ACQ, SAST_CONVERT_STROBE, SAST_PDOWN, SAST_WAKE
  } sast_seq_t;
  typedef logic [1:0] sast_acq_sel_t;
endpackage

/* File: logic/sast_sync.sv */
// two-flop synchroniser with edge detection on the second stage
`timescale 1ns/1ns
module sast_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  input  wire logic d_i,
  output logic      q_o,
  output logic      rise_o,
  output logic      fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sast_sync_st_t;
  sast_sync_st_t st, next_st;
  always_comb begin
    next_st    = st;
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      // reset to the pin's idle level so no false edge follows reset
      st <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL};
    end else begin
      st <= next_st;
    end
  end
  assign q_o    = st.s2;
  assign rise_o = st.s2 & ~st.s3;
  assign fall_o = ~st.s2 & st.s3;
endmodule // sast_sync

/* File: dv/sast_host.sv */
// host model that drives the serial port of the converter block
`timescale 1ns/1ns
module sast_host (
  input  wire logic clk_sys_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      serial_in_o
);
  logic last_q = 1'b0;
  logic line_lvl;
  // no pull on the data line: once released it shows the inverse of its last driven value
  assign line_lvl = sdo_oe_i ? sdo_i : ~last_q;
  always_ff @(posedge clk_sys_i) begin
    if (sdo_oe_i) begin
      last_q <= sdo_i;
    end
  end
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    serial_in_o = 1'b0;
  end
  task automatic half();
    repeat (8) @(negedge clk_sys_i);
  endtask
  // serial clock stands low outside frames; half period is 80 ns
  task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge clk_sys_i);
    cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      serial_in_o = (i < 8) ? cmd[7 - i] : 1'b0;
      half();
      sclk_o = 1'b1;
      rx = {rx[14:0], line_lvl};
      half();
      sclk_o = 1'b0;
    end
    half();
    cs_n_o = 1'b1;
    serial_in_o = ~serial_in_o;
    // select stays high a while so back-to-back frames are seen apart
    half();
  endtask
endmodule // sast_host

/* File: dv/testbench.sv */
// self-checking bench for the converter sequencing and serial port block
`timescale 1ns/1ns
module testbench;
  import sast_pkg::*;
  localparam int PU = 200;
  localparam int CK = 8;
  logic          clk_sys_i = 1'b0;
  logic          srst_i = 1'b1;
  logic          conversion_clock = 1'b0;
  logic          sclk, cs_n, sdi, sdo, oe, rdy, eoc, smp, bad;
  logic          strobe_n = 1'b1;
  logic          pd = 1'b0;
  logic          res8 = 1'b0;
  sast_acq_sel_t acq = 2'h0;
  logic [15:0]   result = 16'h0000;
  logic [15:0]   lfsr = 16'hB027;
  logic [15:0]   rx;
  logic [15:0]   exp_q[$];
  int            fail_count = 0;
  int            samples_checked = 0;
  int            n;
  int            acq_len[4] = '{6, 10, 18, 34};
  int            seq_len[2] = '{4944, 76};
  logic [7:0]    seq_cmd[2] = '{8'h08, 8'h09};
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always #40 conversion_clock = ~conversion_clock;
  sast_top #(.PU_CYCLES(PU)) dut_u (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .conversion_clock_i(conversion_clock), .sclk_i(sclk),
    .cs_n_i(cs_n), .serial_in_i(sdi), .convert_strobe_i(strobe_n), .powerdown_pin_i(pd),
    .res8_i(res8), .acq_sel_i(acq), .result_i(result), .sdo_o(sdo), .sdo_oe_o(oe),
    .output_ready_flag_o(rdy), .eoc_o(eoc), .sample_o(smp), .result_bad_o(bad)
  );
  sast_host host_u (
    .clk_sys_i(clk_sys_i), .sdo_i(sdo), .sdo_oe_i(oe), .sclk_o(sclk), .cs_n_o(cs_n), .serial_in_o(sdi)
  );
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // bounded wait; n returns the cycles spent
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (s !== v && cnt < lim) begin
      @(negedge clk_sys_i);
      cnt++;
    end
    if (s !== v) begin
      fail_count++;
      $display("mismatch wait_level expected %0h seen %0h", v, s);
      finish_test();
    end
  endtask
  // strobe held low through a whole frame, so its evaluation window sees it
  task automatic start_convert_strobe();
    logic [15:0] unused_rx;
    @(negedge clk_sys_i);
    strobe_n = 1'b0;
    fork
      begin
        host_u.xfer(8'h00, 8, unused_rx);
        strobe_n = 1'b1;
      end
    join_none
  endtask
  always @(negedge cs_n) begin
    repeat (5) @(negedge clk_sys_i);
    chk("ready_low", 1'b0, rdy);
    chk("oe_on", 1'b1, oe);
  end
  always @(posedge cs_n) begin
    repeat (5) @(negedge clk_sys_i);
    chk("oe_off", 1'b0, oe);
  end
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    fail_count++;
    $display("mismatch run_length expected done seen hang");
    finish_test();
  end
  initial begin
    repeat (16) @(negedge clk_sys_i);
    chk("reset_outs", 6'b001100, {sdo, oe, rdy, eoc, smp, bad});
    srst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    for (int k = 0; k < 4; k++) begin
      lfsr = nxt(lfsr);
      result = lfsr;
      res8 = lfsr[3];
      acq = sast_acq_sel_t'(k);
      start_convert_strobe();
      wait_lvl(smp, 1'b1, 20 * CK + 16, n);
      wait_lvl(smp, 1'b0, (acq_len[k] + 2) * CK, n);
      chk("sample_len", 1'b1, n >= (acq_len[k] - 1) * CK && n <= (acq_len[k] + 1) * CK);
      wait_lvl(eoc, 1'b1, ((res8 ? 21 : 44) + 2) * CK, n);
      chk("convert_strobe_len", 1'b1, n <= ((res8 ? 21 : 44) + 1) * CK);
      exp_q.push_back(result);
      host_u.xfer(8'h00, 16, rx);
      chk("read_word", exp_q.pop_front(), rx);
    end
    for (int k = 0; k < 2; k++) begin
      host_u.xfer(seq_cmd[k], 8, rx);
      chk("ready_back", 1'b1, rdy);
      wait_lvl(eoc, 1'b0, 3 * CK + 8, n);
      wait_lvl(eoc, 1'b1, (seq_len[k] + 3) * CK + 8, n);
    end
    acq = 2'h0;
    start_convert_strobe();
    wait_lvl(smp, 1'b1, 20 * CK + 16, n);
    wait_lvl(smp, 1'b0, 8 * CK, n);
    repeat (2 * CK) @(negedge clk_sys_i);
    pd = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    chk("pd_bad", 2'b10, {bad, eoc});
    pd = 1'b0;
    wait_lvl(eoc, 1'b1, PU, n);
    host_u.xfer(8'h0B, 8, rx);
    wait_lvl(eoc, 1'b0, 16, n);
    host_u.xfer(8'h0A, 8, rx);
    wait_lvl(eoc, 1'b1, PU, n);
    repeat (10) @(negedge clk_sys_i);
    finish_test();
  end
endmodule // testbench
